// File: bench/gpib_talker_listener_status_test.sv
// Testbench: self-checking run of the GPIB device block
`timescale 1ns/1ps
module gpib_talker_listener_status_test;
  logic sys_clk = 0, rst_n = 0, ce = 1, avRead = 0, avWrite = 0, overVoltage = 0, panelBusy = 0;
  logic [4:0] avAddress = '0;
  logic [31:0] avWritedata = '0, avReaddata_q, q;
  logic [7:0] dioIn, dioOut_q, dioOe_q, hDio;
  logic avWaitrequest_q, davIn, davOut_q, davOe_q, nrfdIn, nrfdOut_q, nrfdOe_q, ndacIn, hDav;
  logic ndacOut_q, ndacOe_q, eoiIn, eoiOut_q, eoiOe_q, atnIn, ifcIn, renIn, srqOut_q, srqOe_q;
  logic hEoi, remoteMode_q, localLockout_q, triggerPulse_q, parserReset_q;
  int n_fail = 0, checks = 0, i;
  // Open-drain wires: low wins, released lines sit at the pull-up
  assign dioIn = hDio & (~dioOe_q | dioOut_q);
  assign davIn = hDav & ~davOe_q;
  assign eoiIn = hEoi & ~eoiOe_q;
  assign nrfdIn = ~nrfdOe_q;
  assign ndacIn = ~ndacOe_q;
  always #12.5 sys_clk = ~sys_clk;
  gpibts_device #(.HOLD_CYCLES(20)) uut (.*);
  gpibts_host host (.sys_clk, .nrfd(nrfdIn), .ndac(ndacIn), .dio(hDio), .dav(hDav),
    .eoi(hEoi), .atn(atnIn), .ifc(ifcIn), .ren(renIn));
  task results;
    n_fail += host.errs;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Avalon access held until waitrequest is sampled low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avAddress <= a;
    avWrite <= w;
    avRead <= !w;
    avWritedata <= d;
    for (i = 0; i < 99 && avWaitrequest_q !== 1'b0; i++) @(posedge sys_clk);
    q = avReaddata_q;
    avRead <= 0;
    avWrite <= 0;
    if (i == 99)
    begin
      n_fail++;
      results;
    end
  endtask
  task rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(0, a, 0);
    cmp(q & m, e);
  endtask
  task t_addr;
    rd(5'h00, 32'h1F, 32'h01);
    bus(1, 5'h00, 32'h1E);
    bus(1, 5'h00, 32'h1F);
    rd(5'h00, 32'h1F, 32'h1E);
    rd(5'h18, '1, 32'h0);
    $display("addr done");
  endtask
  task t_listen;
    host.setl(1, 0, 1);
    host.send(1, 0, 8'h3E);
    cmp(remoteMode_q, 1);
    host.send(0, 1, 8'h41);
    rd(5'h08, 32'h3FF, 32'h341);
    host.send(0, 0, 8'h0A);
    rd(5'h08, 32'h3FF, 32'h30A);
    host.send(0, 0, 8'h0D);
    rd(5'h08, 32'h3FF, 32'h20D);
    host.send(1, 0, 8'h11);
    // Lockout output follows the lockout state one clock later
    @(posedge sys_clk);
    cmp(localLockout_q, 1);
    $display("listen done");
  endtask
  task t_busy;
    host.send(1, 0, 8'h08);
    rd(5'h14, 32'h2, 32'h2);
    rd(5'h04, 32'h80, 32'h80);
    bus(1, 5'h10, 32'h10);
    rd(5'h14, 32'h8, 32'h8);
    bus(1, 5'h10, 32'h02);
    panelBusy <= 1;
    rd(5'h04, 32'h80, 32'h80);
    panelBusy <= 0;
    bus(1, 5'h10, 32'h10);
    rd(5'h14, 32'h10, 32'h10);
    $display("busy done");
  endtask
  task t_surge;
    overVoltage <= 1;
    rd(5'h04, 32'hE0, 32'hE0);
    cmp(srqOe_q, 1);
    overVoltage <= 0;
    rd(5'h04, 32'h80, 32'h80);
    repeat (30) @(posedge sys_clk);
    rd(5'h04, 32'h80, 32'h0);
    bus(1, 5'h10, 32'h08);
    rd(5'h04, 32'h20, 32'h0);
    $display("surge done");
  endtask
  task t_poll;
    host.send(1, 0, 8'h18);
    host.send(1, 0, 8'h5E);
    host.setl(0, 0, 1);
    for (i = 0; i < 99 && davOe_q !== 1'b1; i++) @(posedge sys_clk);
    if (i == 99)
    begin
      n_fail++;
      results;
    end
    // Concatenation keeps the inversion to eight bits
    cmp({~dioOut_q}, 8'h40);
    host.setl(0, 1, 1);
    repeat (4) @(posedge sys_clk);
    host.setl(1, 0, 1);
    rd(5'h14, 32'h4, 32'h4);
    host.send(1, 0, 8'h14);
    rd(5'h14, 32'h1, 32'h1);
    bus(1, 5'h10, 32'h04);
    rd(5'h04, 32'h47, 32'h41);
    $display("poll done");
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1;
    t_addr;
    t_listen;
    t_busy;
    t_surge;
    t_poll;
    results;
  end
endmodule

// File: bench/gpibts_chk.sv
// Checker: port assertions for the GPIB device block
`timescale 1ns/1ps
module gpibts_chk
#(
  parameter int unsigned HOLD_CYCLES = 20
)
(
  // Clock, reset and bus levels
  input wire logic       sys_clk, rst_n, ifcIn, renIn, atnIn, nrfdIn,
  // Driven by the block
  input wire logic       davOe_q, davOut_q, srqOe_q, triggerPulse_q,
  input wire logic       remoteMode_q, localLockout_q, parserReset_q,
  input wire logic [7:0] dioOe_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Bus inputs may be synchronised, so level rules allow two cycles
  a_trig_single: assert property (triggerPulse_q |=> !triggerPulse_q)
    else $error("trigger longer than one cycle");
  a_ren_local: assert property (renIn [*3] |-> !remoteMode_q && !localLockout_q)
    else $error("remote kept with enable released");
  a_lock_remote: assert property (localLockout_q |-> remoteMode_q)
    else $error("lockout outside remote");
  a_ifc_parser: assert property (!ifcIn [*3] |-> parserReset_q)
    else $error("parser not reset by clear");
  a_ifc_quiet: assert property (!ifcIn [*3] |-> dioOe_q == 8'h00 && !davOe_q)
    else $error("bus driven during clear");
  a_dav_ready: assert property ($rose(davOe_q) |-> $past(nrfdIn))
    else $error("valid before ready");
  a_dav_data: assert property (davOe_q |-> dioOe_q == 8'hFF)
    else $error("valid without data");
  a_atn_quiet: assert property (!atnIn [*3] |-> !davOe_q)
    else $error("talking under attention");
  a_drain_only: assert property (!davOut_q)
    else $error("line driven high");
  c_trig: cover property (triggerPulse_q);
  c_srq: cover property (srqOe_q);
  c_talk: cover property (davOe_q);
endmodule

bind gpibts_device gpibts_chk #(.HOLD_CYCLES(HOLD_CYCLES)) chk (.*);

// File: bench/gpibts_host.sv
// Model: GPIB system controller on the far side of the bus
`timescale 1ns/1ps
module gpibts_host
(
  // Wire levels seen on the bus
  input wire logic  sys_clk, nrfd, ndac,
  // Lines driven by the controller, low is true
  output logic [7:0] dio,
  output logic       dav, eoi, atn, ifc, ren
);
  int errs = 0;
  int i;
  initial {dio, dav, eoi, atn, ifc, ren} = '1;
  // Management lines, arguments active high
  task setl(input logic a, input logic c, input logic r);
    @(posedge sys_clk);
    atn <= !a;
    ifc <= !c;
    ren <= !r;
  endtask
  // One byte by three-wire handshake; released data float to the pull-up
  task send(input logic a, input logic e, input logic [7:0] d);
    if (a && d == 8'h14) repeat (40000) @(posedge sys_clk);
    @(posedge sys_clk);
    atn <= !a;
    eoi <= !e;
    dio <= ~d;
    for (i = 0; i < 99 && !nrfd; i++) @(posedge sys_clk);
    if (i == 99) errs++;
    @(posedge sys_clk);
    dav <= 1'b0;
    for (i = 0; i < 99 && !ndac; i++) @(posedge sys_clk);
    if (i == 99) errs++;
    dav <= 1'b1;
    eoi <= 1'b1;
    dio <= 8'hFF;
  endtask
endmodule

// File: rtl/gpibts_device.sv
// Module: device-side GPIB talker/listener with serial poll status
//
// Contract
// - Basic talker answering serial polls; own talk address drops listening.
// - Basic listener; own listen address drops talking.
// - No secondary addressing and no controller role.
// - Remote/local switching with local lockout disabling the front panel.
// - Parallel poll (attention with end) is ignored.
// - Device clear releases data lines, resets parser, readies input.
// - Group execute trigger starts operation like the trigger command.
// - Serial poll places the current status byte on the data lines.
// - Busy flag is set while processing, panel or remote work.
// - While busy, guarded commands are refused with the busy error.
// - Over-voltage raises service request, busy, request and surge flags.
// - Busy stays set five seconds after over-voltage goes away.
// - Surge flag holds until cleared; no new surge request before.
// - A ready reply raises service request and the request flag.
// - Status byte holds a three-bit binary reply-state field.
// - Three input terminator forms accepted (LF, LF with end, end); CR setting makes CR terminate.
// - Output ends follow none, LF, CR or CR-LF setting with end.
// - Primary address settable from 0 to 30.
// - Interface clear abandons the transfer and discards buffered message.
// - Surge clear command clears the over-voltage flag.
`timescale 1ns/1ps
module gpibts_device
#(
  parameter int unsigned HOLD_CYCLES = gpibts_pkg::OV_HOLD_CYC
)
(
  // Clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [4:0]  avAddress,
  input  wire logic        avRead,
  input  wire logic        avWrite,
  input  wire logic [31:0] avWritedata,
  output logic      [31:0] avReaddata_q,
  output logic             avWaitrequest_q,
  // GPIB data lines, bus levels, low is true
  input  wire logic [7:0]  dioIn,
  output logic      [7:0]  dioOut_q,
  output logic      [7:0]  dioOe_q,
  // GPIB handshake and management, bus levels
  input  wire logic        davIn,
  output logic             davOut_q,
  output logic             davOe_q,
  input  wire logic        nrfdIn,
  output logic             nrfdOut_q,
  output logic             nrfdOe_q,
  input  wire logic        ndacIn,
  output logic             ndacOut_q,
  output logic             ndacOe_q,
  input  wire logic        eoiIn,
  output logic             eoiOut_q,
  output logic             eoiOe_q,
  input  wire logic        atnIn,
  input  wire logic        ifcIn,
  input  wire logic        renIn,
  output logic             srqOut_q,
  output logic             srqOe_q,
  // Instrument side
  input  wire logic        overVoltage,
  input  wire logic        panelBusy,
  output logic             remoteMode_q,
  output logic             localLockout_q,
  output logic             triggerPulse_q,
  output logic             parserReset_q
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    AH_IDLE  = 3'b001,
    AH_READY = 3'b010,
    AH_DONE  = 3'b100
  } gpibts_ah_t;
  typedef enum logic [2:0] {
    SH_IDLE  = 3'b001,
    SH_SETUP = 3'b010,
    SH_VALID = 3'b100
  } gpibts_sh_t;

  gpibts_ah_t ahState_q;
  gpibts_sh_t shState_q;
  logic [4:0] myAddr_q;
  logic       inTermCr_q;
  logic [1:0] outTerm_q;
  logic [2:0] devState_q;
  logic       listen_q, talk_q, spoll_q, lockout_q;
  logic [7:0] rxData_q, txData_q;
  logic       rxEnd_q, rxValid_q, txLast_q, txValid_q, needCr_q, needLf_q;
  logic       ovFlag_q, replyPend_q, workBusy_q;
  logic [gpibts_pkg::EVT_W-1:0] evt_q;
  logic        atnT, eoiT, davT, nrfdT, ndacT, ifcT, renT;
  logic [7:0]  busByte, statusByte, srcByte;
  logic [6:0]  msg;
  logic        take, cmdTake, dataTake, isMla, isMta, dclStrobe, getStrobe;
  logic        clearAll, talkActive, haveByte, srcEoi, shDone, spollDone;
  logic        replySent, busy, holdRun, accessNow, wrCtrl, wrTx, wrCmd, wrEvt;
  logic        rdRx, rxEndNow;
  logic [31:0] readMux;

  // Bus lines are active low; work with true levels inside
  assign atnT    = ~atnIn;
  assign eoiT    = ~eoiIn;
  assign davT    = ~davIn;
  assign nrfdT   = ~nrfdIn;
  assign ndacT   = ~ndacIn;
  assign ifcT    = ~ifcIn;
  assign renT    = ~renIn;
  assign busByte = ~dioIn;
  assign msg     = busByte[6:0];

  // ------------------------------------------------------------
  // Avalon slave: answer one cycle after the request is seen
  // ------------------------------------------------------------
  assign accessNow = (avRead | avWrite) & ~avWaitrequest_q;
  assign wrCtrl = accessNow & avWrite & (avAddress == gpibts_pkg::OFS_CTRL);
  assign wrTx   = accessNow & avWrite & (avAddress == gpibts_pkg::OFS_TXD);
  assign wrCmd  = accessNow & avWrite & (avAddress == gpibts_pkg::OFS_CMD);
  assign wrEvt  = accessNow & avWrite & (avAddress == gpibts_pkg::OFS_EVT);
  // Pop only what was actually returned, so a byte landing late is kept
  assign rdRx   = accessNow & avRead & (avAddress == gpibts_pkg::OFS_RXD)
                & avReaddata_q[gpibts_pkg::RXD_VALID];

  // Read data mux; unmapped offsets read as zero
  always_comb
  begin
    readMux = '0;
    case (avAddress)
      gpibts_pkg::OFS_CTRL: readMux = {21'h0, devState_q, outTerm_q, inTermCr_q, myAddr_q};
      gpibts_pkg::OFS_STAT: readMux = {17'h0, txValid_q, rxValid_q, spoll_q, lockout_q,
                                       remoteMode_q, talk_q, listen_q, statusByte};
      gpibts_pkg::OFS_RXD:  readMux = {22'h0, rxValid_q, rxEnd_q, rxData_q};
      gpibts_pkg::OFS_EVT:  readMux = {27'h0, evt_q};
      default:              readMux = '0;
    endcase
  end

  // Waitrequest; a transmit write stalls while the byte slot is full
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avWaitrequest_q <= 1'b1;
      avReaddata_q    <= '0;
    end
    else if (ce)
    begin
      if (accessNow)
        avWaitrequest_q <= 1'b1;
      else if (avRead)
      begin
        avWaitrequest_q <= 1'b0;
        avReaddata_q    <= readMux;
      end
      else if (avWrite && !(avAddress == gpibts_pkg::OFS_TXD && txValid_q))
        avWaitrequest_q <= 1'b0;
    end
  end

  // Configuration; addresses above 30 are refused and the old one kept
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      myAddr_q   <= gpibts_pkg::ADDR_RST;
      inTermCr_q <= 1'b0;
      outTerm_q  <= gpibts_pkg::OUT_NONE;
      devState_q <= '0;
    end
    else if (ce && wrCtrl)
    begin
      if (avWritedata[gpibts_pkg::CTRL_ADDR_LO +: 5] <= gpibts_pkg::ADDR_MAX)
        myAddr_q <= avWritedata[gpibts_pkg::CTRL_ADDR_LO +: 5];
      inTermCr_q <= avWritedata[gpibts_pkg::CTRL_TERM_CR];
      outTerm_q  <= avWritedata[gpibts_pkg::CTRL_OUT_LO +: 2];
      devState_q <= avWritedata[gpibts_pkg::CTRL_SSS_LO +: 3];
    end
  end

  // ------------------------------------------------------------
  // Bus message decode
  // ------------------------------------------------------------
  assign take     = (ahState_q == AH_READY) & davT & (atnT | ~rxValid_q);
  assign cmdTake  = take & atnT;
  assign dataTake = take & ~atnT & listen_q;
  // Secondary codes 60..7F never match anything, so they fall through
  assign isMla = cmdTake && msg == {gpibts_pkg::GRP_LISTEN, myAddr_q};
  assign isMta = cmdTake && msg == {gpibts_pkg::GRP_TALK, myAddr_q};
  assign dclStrobe = cmdTake & ((msg == gpibts_pkg::MSG_DCL)
                   | (msg == gpibts_pkg::MSG_SDC & listen_q));
  assign getStrobe = cmdTake & (msg == gpibts_pkg::MSG_GET) & listen_q;
  assign clearAll  = ifcT | dclStrobe;

  // Addressing: interface clear idles talker, listener and serial poll
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      listen_q <= 1'b0;
      talk_q   <= 1'b0;
      spoll_q  <= 1'b0;
    end
    else if (ce)
    begin
      if (ifcT)
      begin
        listen_q <= 1'b0;
        talk_q   <= 1'b0;
        spoll_q  <= 1'b0;
      end
      else if (cmdTake)
      begin
        if (isMla)
        begin
          listen_q <= 1'b1;
          talk_q   <= 1'b0;
        end
        else if (isMta)
        begin
          talk_q   <= 1'b1;
          listen_q <= 1'b0;
        end
        else if (msg[6:5] == gpibts_pkg::GRP_TALK)
          talk_q <= 1'b0; // Other talk address or untalk
        if (msg == gpibts_pkg::MSG_UNL)
          listen_q <= 1'b0;
        if (msg == gpibts_pkg::MSG_SPE)
          spoll_q <= 1'b1;
        else if (msg == gpibts_pkg::MSG_SPD)
          spoll_q <= 1'b0;
      end
    end
  end

  // Remote/local: remote enable must stand; lockout survives go-to-local
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remoteMode_q   <= 1'b0;
      lockout_q      <= 1'b0;
      localLockout_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!renT)
      begin
        remoteMode_q <= 1'b0;
        lockout_q    <= 1'b0;
      end
      else if (cmdTake)
      begin
        if (isMla)
          remoteMode_q <= 1'b1;
        else if (msg == gpibts_pkg::MSG_GTL && listen_q)
          remoteMode_q <= 1'b0;
        if (msg == gpibts_pkg::MSG_LLO)
          lockout_q <= 1'b1;
      end
      localLockout_q <= renT & lockout_q & remoteMode_q;
    end
  end

  // ------------------------------------------------------------
  // Acceptor handshake
  // ------------------------------------------------------------
  // Engaged for every command, and for data only while addressed to listen.
  // Attention with end and no valid byte is a parallel poll: never answered.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ahState_q <= AH_IDLE;
      nrfdOe_q  <= 1'b0;
      ndacOe_q  <= 1'b0;
    end
    else if (ce)
    begin
      unique case (ahState_q)
        AH_IDLE:
        begin
          nrfdOe_q <= 1'b0;
          ndacOe_q <= 1'b0;
          if (atnT | listen_q)
          begin
            ahState_q <= AH_READY;
            nrfdOe_q  <= 1'b1;
            ndacOe_q  <= 1'b1;
          end
        end
        AH_READY:
        begin
          nrfdOe_q <= ~(atnT | ~rxValid_q); // Full receive slot holds off talker
          if (!(atnT | listen_q) || ifcT)
            ahState_q <= AH_IDLE;
          else if (take)
          begin
            ahState_q <= AH_DONE;
            nrfdOe_q  <= 1'b1;
            ndacOe_q  <= 1'b0;
          end
        end
        AH_DONE:
        begin
          if (!davT)
          begin
            ahState_q <= AH_READY;
            ndacOe_q  <= 1'b1;
          end
        end
      endcase
    end
  end

  // Input terminators: end line, LF, or CR when the CR setting is chosen
  assign rxEndNow = eoiT | (busByte == gpibts_pkg::CHAR_LF)
                  | (inTermCr_q & (busByte == gpibts_pkg::CHAR_CR));

  // Receive slot
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxData_q  <= '0;
      rxEnd_q   <= 1'b0;
      rxValid_q <= 1'b0;
    end
    else if (ce)
    begin
      if (clearAll)
        rxValid_q <= 1'b0;
      else if (dataTake)
      begin
        rxData_q  <= busByte;
        rxEnd_q   <= rxEndNow;
        rxValid_q <= 1'b1;
      end
      else if (rdRx)
        rxValid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Source handshake
  // ------------------------------------------------------------
  assign talkActive = talk_q & ~atnT;
  assign haveByte   = spoll_q | needCr_q | needLf_q | txValid_q;
  assign shDone     = (shState_q == SH_VALID) & ~ndacT & talkActive & ~clearAll;
  assign spollDone  = shDone & spoll_q;
  assign replySent  = shDone & ~spoll_q & ~needCr_q & ~needLf_q & txLast_q;

  // Byte selection: status byte under serial poll, then terminators
  always_comb
  begin
    srcByte = txData_q;
    srcEoi  = txLast_q & (outTerm_q == gpibts_pkg::OUT_NONE);
    if (spoll_q)
    begin
      srcByte = statusByte;
      srcEoi  = 1'b0;
    end
    else if (needCr_q)
    begin
      srcByte = gpibts_pkg::CHAR_CR;
      srcEoi  = ~needLf_q;
    end
    else if (needLf_q)
    begin
      srcByte = gpibts_pkg::CHAR_LF;
      srcEoi  = 1'b1;
    end
  end

  // Talker state machine; attention or clear drops the lines at once
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shState_q <= SH_IDLE;
      dioOut_q  <= 8'hFF;
      dioOe_q   <= 8'h00;
      davOe_q   <= 1'b0;
      eoiOe_q   <= 1'b0;
    end
    else if (ce)
    begin
      if (!talkActive || clearAll || shDone)
      begin
        shState_q <= SH_IDLE;
        dioOe_q   <= 8'h00;
        davOe_q   <= 1'b0;
        eoiOe_q   <= 1'b0;
      end
      else
      begin
        unique case (shState_q)
          SH_IDLE:
            if (haveByte)
            begin
              shState_q <= SH_SETUP;
              dioOut_q  <= ~srcByte;
              dioOe_q   <= 8'hFF;
              eoiOe_q   <= srcEoi;
            end
          SH_SETUP:
            if (!nrfdT)
            begin
              shState_q <= SH_VALID;
              davOe_q   <= 1'b1;
            end
          SH_VALID:
            shState_q <= SH_VALID;
        endcase
      end
    end
  end

  // Transmit slot and output terminator sequencing
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txData_q  <= '0;
      txLast_q  <= 1'b0;
      txValid_q <= 1'b0;
      needCr_q  <= 1'b0;
      needLf_q  <= 1'b0;
    end
    else if (ce)
    begin
      if (clearAll)
      begin
        txValid_q <= 1'b0;
        needCr_q  <= 1'b0;
        needLf_q  <= 1'b0;
      end
      else
      begin
        if (wrTx)
        begin
          txData_q  <= avWritedata[7:0];
          txLast_q  <= avWritedata[gpibts_pkg::TXD_LAST];
          txValid_q <= 1'b1;
        end
        if (shDone && !spoll_q)
        begin
          if (needCr_q)
            needCr_q <= 1'b0;
          else if (needLf_q)
            needLf_q <= 1'b0;
          else
          begin
            txValid_q <= 1'b0;
            needCr_q  <= txLast_q & (outTerm_q == gpibts_pkg::OUT_CR
                                   | outTerm_q == gpibts_pkg::OUT_CL);
            needLf_q  <= txLast_q & (outTerm_q == gpibts_pkg::OUT_LF
                                   | outTerm_q == gpibts_pkg::OUT_CL);
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Status byte, service request and busy
  // ------------------------------------------------------------
  gpibts_hold_timer #(
    .CYCLES (HOLD_CYCLES)
  ) u_hold (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .restart   (overVoltage),
    .running_q (holdRun)
  );

  // Busy runs on until the hold expires after the surge is gone
  assign busy = workBusy_q | panelBusy | overVoltage | holdRun;

  always_comb
  begin
    statusByte = '0;
    statusByte[gpibts_pkg::SB_BUSY] = busy;
    statusByte[gpibts_pkg::SB_RQS]  = srqOe_q;
    statusByte[gpibts_pkg::SB_OV]   = ovFlag_q;
    statusByte[gpibts_pkg::SB_SSS_LO +: 3] = replyPend_q ? gpibts_pkg::SSS_REPLY
                                                         : devState_q;
  end

  // Sticky flags; a setting event wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ovFlag_q    <= 1'b0;
      srqOe_q     <= 1'b0;
      replyPend_q <= 1'b0;
      workBusy_q  <= 1'b0;
    end
    else if (ce)
    begin
      if (overVoltage)
        ovFlag_q <= 1'b1;
      else if (wrCmd && avWritedata[gpibts_pkg::CMD_SURGE])
        ovFlag_q <= 1'b0;
      // A surge only requests service once until its flag is cleared
      if ((overVoltage && !ovFlag_q) || (wrCmd && avWritedata[gpibts_pkg::CMD_REPLY]))
        srqOe_q <= 1'b1;
      else if (spollDone)
        srqOe_q <= 1'b0;
      if (wrCmd && avWritedata[gpibts_pkg::CMD_REPLY])
        replyPend_q <= 1'b1;
      else if (replySent)
        replyPend_q <= 1'b0;
      if (getStrobe || (wrCmd && avWritedata[gpibts_pkg::CMD_SET_BUSY]))
        workBusy_q <= 1'b1;
      else if (wrCmd && avWritedata[gpibts_pkg::CMD_CLR_BUSY])
        workBusy_q <= 1'b0;
    end
  end

  // Events for the parser, write one to clear; pulses to the instrument
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_q          <= '0;
      triggerPulse_q <= 1'b0;
      parserReset_q  <= 1'b0;
    end
    else if (ce)
    begin
      evt_q <= (evt_q & ~({gpibts_pkg::EVT_W{wrEvt}} & avWritedata[gpibts_pkg::EVT_W-1:0]))
             | ({gpibts_pkg::EVT_W{1'b0}}
             | (gpibts_pkg::EVT_W'(dclStrobe) << gpibts_pkg::EVT_DCL)
             | (gpibts_pkg::EVT_W'(getStrobe) << gpibts_pkg::EVT_GET)
             | (gpibts_pkg::EVT_W'(ifcT) << gpibts_pkg::EVT_IFC)
             | (gpibts_pkg::EVT_W'(wrCmd & avWritedata[gpibts_pkg::CMD_GUARDED] & busy)
                << gpibts_pkg::EVT_REJ)
             | (gpibts_pkg::EVT_W'(wrCmd & avWritedata[gpibts_pkg::CMD_GUARDED] & ~busy)
                << gpibts_pkg::EVT_OK));
      triggerPulse_q <= getStrobe;
      parserReset_q  <= clearAll;
    end
  end

  // Open-drain lines only ever pull low
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      davOut_q  <= 1'b0;
      nrfdOut_q <= 1'b0;
      ndacOut_q <= 1'b0;
      eoiOut_q  <= 1'b0;
      srqOut_q  <= 1'b0;
    end
  end
endmodule

// File: rtl/gpibts_hold_timer.sv
// Module: restartable hold counter that stretches a level
`timescale 1ns/1ps
module gpibts_hold_timer
#(
  parameter int unsigned CYCLES = 200_000_000
)
(
  // Clock, reset, enable
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Control and status
  input  wire logic restart,
  output logic      running_q
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] count_q;

  // Reload while the cause stands, then run down to zero
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q   <= '0;
      running_q <= 1'b0;
    end
    else if (ce)
    begin
      if (restart)
      begin
        count_q   <= W'(CYCLES);
        running_q <= 1'b1;
      end
      else if (count_q != '0)
      begin
        count_q   <= count_q - 1'b1;
        running_q <= (count_q != W'(1));
      end
    end
  end
endmodule

// File: rtl/gpibts_pkg.sv
// Package: shared constants for the GPIB talker/listener status block
package gpibts_pkg;
  // ------------------------------------------------------------
  // Register map (byte offsets)
  // ------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STAT = 5'h04;
  localparam logic [4:0] OFS_RXD  = 5'h08;
  localparam logic [4:0] OFS_TXD  = 5'h0C;
  localparam logic [4:0] OFS_CMD  = 5'h10;
  localparam logic [4:0] OFS_EVT  = 5'h14;
  // Control fields and reset values
  localparam int         CTRL_ADDR_LO = 0;
  localparam int         CTRL_TERM_CR = 5;
  localparam int         CTRL_OUT_LO  = 6;
  localparam int         CTRL_SSS_LO  = 8;
  localparam logic [4:0] ADDR_MAX     = 5'h1E;
  localparam logic [4:0] ADDR_RST     = 5'h01;
  localparam int         RXD_VALID    = 9;
  localparam int         TXD_LAST     = 8;
  // Output terminator settings
  localparam logic [1:0] OUT_NONE = 2'h0;
  localparam logic [1:0] OUT_LF   = 2'h1;
  localparam logic [1:0] OUT_CR   = 2'h2;
  localparam logic [1:0] OUT_CL   = 2'h3;
  // Status byte layout
  localparam int         SB_BUSY   = 7;
  localparam int         SB_RQS    = 6;
  localparam int         SB_OV     = 5;
  localparam int         SB_SSS_LO = 0;
  localparam logic [2:0] SSS_REPLY = 3'h1;
  // Command register bits
  localparam int CMD_SET_BUSY = 0;
  localparam int CMD_CLR_BUSY = 1;
  localparam int CMD_REPLY    = 2;
  localparam int CMD_SURGE    = 3;
  localparam int CMD_GUARDED  = 4;
  // Event register bits
  localparam int EVT_DCL = 0;
  localparam int EVT_GET = 1;
  localparam int EVT_IFC = 2;
  localparam int EVT_REJ = 3;
  localparam int EVT_OK  = 4;
  localparam int EVT_W   = 5;
  // Bus messages, seven bits, sent with attention asserted; CR and LF are eight-bit data characters
  localparam logic [6:0] MSG_GTL    = 7'h01;
  localparam logic [6:0] MSG_SDC    = 7'h04;
  localparam logic [6:0] MSG_GET    = 7'h08;
  localparam logic [6:0] MSG_LLO    = 7'h11;
  localparam logic [6:0] MSG_DCL    = 7'h14;
  localparam logic [6:0] MSG_SPE    = 7'h18;
  localparam logic [6:0] MSG_SPD    = 7'h19;
  localparam logic [6:0] MSG_UNL    = 7'h3F;
  localparam logic [6:0] MSG_UNT    = 7'h5F;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK   = 2'h2;
  localparam logic [7:0] CHAR_CR    = 8'h0D;
  localparam logic [7:0] CHAR_LF    = 8'h0A;
  // Timing
  localparam int CLK_HZ      = 40_000_000;
  localparam int OV_HOLD_S   = 5;
  localparam int OV_HOLD_CYC = CLK_HZ * OV_HOLD_S;
endpackage
